// >>> adc_convert_ctrl.sv
// Purpose: convert start, busy, power-down and serial readout of a 12-bit sampling converter
// Assumes: conv_data is valid from the converter core at the end of each conversion;
//          sclk is supplied by the host and stands low between frames
// Notes:   the serial side runs on sclk falling edges; the result word is held stable
//          in the clk domain while a frame may be read
// Overview of operation
// [RL1] convert start acts on its edges, never on its level; the code samples its level at end of conversion to choose power-down (RL5)
// [RL2] falling convert start puts track-and-hold into hold and starts conversion
// [RL3] busy rises on the falling edge of convert start
// [RL4] busy returns low when conversion completes
// [RL5] convert start still low at end of conversion sends the device to power-down
// [RL6] a rising convert start edge wakes the device from power-down
// [RL7] end of conversion returns track-and-hold to tracking, starting acquisition
// [RL8] host waits one acquisition interval before the next conversion
// [RL9] a new serial bit leaves on every falling serial clock edge
// [RL10] the previous bit stays valid briefly after each falling serial clock edge
// [RL11] frame is sixteen bits: four zeros then twelve data bits
// [RL12] after the sixteenth falling edge, last bit is held then output released
// [RL13] result is plain unsigned binary
// [RL14] host returns serial clock low after a frame
// [RL15] conversion takes 8 us, or 14 us from wake-up in auto-sleep
// [RL16] host does not read during conversion nor 400 ns before the next
// [RL17] after wake-up, hold comes 6 us after the rising edge
// [RL18] data bits go out most significant first after the zeros
`timescale 1ns/10ps
module adc_convert_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int DW       = DATA_W,
  parameter int CONV_LEN = CONV_CYC,
  parameter int WAKE_LEN = WAKE_CYC
) (
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic          convert_start_n,
  input  wire logic [DW-1:0] conv_data,
  output logic               busy,
  output logic               track_hold,
  output logic               powered_down,
  input  wire logic          sclk,
  output logic               serial_data_out,
  output logic               serial_data_oe
);

  // ---------------------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------------------
  localparam int TMR_W = $clog2(CONV_LEN > WAKE_LEN ? CONV_LEN : WAKE_LEN);
  localparam int CNT_W = $clog2(FRAME_BITS);

  generate
    if (DW + LEAD_ZEROS != FRAME_BITS) begin : g_bad_width
      $error("data width does not fill the frame");
    end
    if (CONV_LEN < 2 || WAKE_LEN < 2) begin : g_bad_time
      $error("conversion and wake counts must be at least two cycles");
    end
  endgenerate

  // 0-based position in the frame: zeros first, then data msb first
  function automatic logic frame_bit(input logic [DW-1:0] word, input int pos);
    logic b;
    b = 1'b0;
    if (pos >= LEAD_ZEROS && pos < FRAME_BITS) begin
      b = word[FRAME_BITS-1-pos];  // [RL18] [RL13]
    end
    return b;
  endfunction : frame_bit

  // ---------------------------------------------------------------------------
  // input crossings into clk
  // ---------------------------------------------------------------------------
  logic cs_lvl;
  logic cs_prev_r;
  logic done_lvl;
  logic done_prev_r;
  logic done_tgl_r;
  logic fall_evt;
  logic rise_evt;
  logic done_evt;

  sync_filter #(.RST_VAL(CONV_N_RST)) u_cs_sync (
    .clk     (clk),
    .resetn  (resetn),
    .d_in    (convert_start_n),
    .level_r (cs_lvl)
  );

  sync_filter #(.RST_VAL(TGL_RST)) u_done_sync (
    .clk     (clk),
    .resetn  (resetn),
    .d_in    (done_tgl_r),
    .level_r (done_lvl)
  );

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cs_prev_r   <= CONV_N_RST;
      done_prev_r <= TGL_RST;
    end else begin
      cs_prev_r   <= cs_lvl;
      done_prev_r <= done_lvl;
    end
  end

  assign fall_evt = cs_prev_r & ~cs_lvl;  // [RL1]
  assign rise_evt = ~cs_prev_r & cs_lvl;  // [RL1]
  assign done_evt = done_prev_r ^ done_lvl;

  // ---------------------------------------------------------------------------
  // conversion control
  // ---------------------------------------------------------------------------
  ctrl_state_t       state_r;
  ctrl_state_t       state_nxt;
  logic [TMR_W-1:0]  timer_r;
  logic [TMR_W-1:0]  timer_nxt;
  logic              busy_r;
  logic              busy_nxt;
  logic              hold_r;
  logic              hold_nxt;
  logic              fall_seen_r;
  logic              fall_seen_nxt;
  logic              oe_r;
  logic              oe_nxt;
  logic [DW-1:0]     result_r;
  logic [DW-1:0]     result_nxt;

  always_comb begin
    state_nxt     = state_r;
    timer_nxt     = (timer_r == '0) ? timer_r : timer_r - TMR_W'(1);
    busy_nxt      = busy_r;
    hold_nxt      = hold_r;
    fall_seen_nxt = fall_seen_r;
    oe_nxt        = oe_r;
    result_nxt    = result_r;
    // a finished frame releases the data line a few clk cycles after edge 16,
    // which keeps the last bit past the required hold time
    if (done_evt) begin
      oe_nxt = 1'b0;  // [RL12] [RL10]
    end
    unique case (state_r)
      ST_ACTIVE: begin
        if (fall_evt) begin
          state_nxt = ST_CONVERT;
          timer_nxt = TMR_W'(CONV_LEN - 1);
          busy_nxt  = 1'b1;  // [RL3]
          hold_nxt  = 1'b1;  // [RL2]
          oe_nxt    = 1'b0;
        end
      end
      ST_CONVERT: begin
        if (timer_r == '0) begin  // [RL15]
          busy_nxt   = 1'b0;  // [RL4]
          hold_nxt   = 1'b0;  // [RL7]
          result_nxt = conv_data;
          oe_nxt     = 1'b1;
          state_nxt  = cs_lvl ? ST_ACTIVE : ST_SLEEP;  // [RL5]
        end
      end
      ST_SLEEP: begin
        if (rise_evt) begin
          state_nxt     = ST_WAKE;  // [RL6]
          timer_nxt     = TMR_W'(WAKE_LEN - 1);
          fall_seen_nxt = 1'b0;
        end
      end
      ST_WAKE: begin
        if (fall_evt) begin
          busy_nxt      = 1'b1;  // [RL3]
          fall_seen_nxt = 1'b1;
          oe_nxt        = 1'b0;
        end
        // a start pulse longer than the wake time falls in ST_ACTIVE instead
        if (timer_r == '0) begin
          if (fall_seen_r || fall_evt) begin
            state_nxt = ST_CONVERT;  // [RL17]
            timer_nxt = TMR_W'(CONV_LEN - 1);
            hold_nxt  = 1'b1;  // [RL17] [RL2]
          end else begin
            state_nxt = ST_ACTIVE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r     <= ST_ACTIVE;
      timer_r     <= '0;
      busy_r      <= 1'b0;
      hold_r      <= 1'b0;
      fall_seen_r <= 1'b0;
      oe_r        <= 1'b0;
      result_r    <= '0;
    end else begin
      state_r     <= state_nxt;
      timer_r     <= timer_nxt;
      busy_r      <= busy_nxt;
      hold_r      <= hold_nxt;
      fall_seen_r <= fall_seen_nxt;
      oe_r        <= oe_nxt;
      result_r    <= result_nxt;
    end
  end

  assign busy           = busy_r;
  assign track_hold     = hold_r;
  assign powered_down   = (state_r == ST_SLEEP);
  assign serial_data_oe = oe_r;

  // ---------------------------------------------------------------------------
  // serial side, sclk falling edges
  // ---------------------------------------------------------------------------
  // result_r only changes at the end of a conversion, while the host keeps off the
  // link; the frame reads it as a word that stands still
  logic             lrst1_r;
  logic             lrst_n_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             data_r;
  logic             data_nxt;
  logic             done_tgl_nxt;

  always_ff @(negedge sclk) begin
    lrst1_r  <= resetn;
    lrst_n_r <= lrst1_r;
  end

  always_comb begin
    cnt_nxt      = cnt_r + CNT_W'(1);  // [RL9]
    data_nxt     = frame_bit(result_r, int'(cnt_r) + 1);  // [RL9] [RL11]
    done_tgl_nxt = done_tgl_r;
    if (cnt_r == CNT_W'(FRAME_BITS - 1)) begin
      data_nxt     = data_r;  // [RL12]
      done_tgl_nxt = ~done_tgl_r;
    end
  end

  always_ff @(negedge sclk) begin
    if (!lrst_n_r) begin
      cnt_r      <= '0;
      data_r     <= 1'b0;
      done_tgl_r <= TGL_RST;
    end else begin
      cnt_r      <= cnt_nxt;
      data_r     <= data_nxt;
      done_tgl_r <= done_tgl_nxt;
    end
  end

  // first leading zero shows before edge 1; after edge 16 the last bit stays until clk side releases
  assign serial_data_out = data_r & ((cnt_r != '0) | (done_tgl_r ^ done_prev_r));  // [RL11] [RL12]

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  localparam int CYC_W    = TMR_W + 1;
  localparam int WAKE_CHK = WAKE_LEN;

  // cycles spent converting, counted apart from the timer so the check does not lean on it
  logic [CYC_W-1:0] conv_cyc_r;
  logic [CYC_W-1:0] conv_cyc_nxt;
  always_comb begin
    conv_cyc_nxt = (state_r == ST_CONVERT) ? conv_cyc_r + CYC_W'(1) : '0;
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      conv_cyc_r <= '0;
    end else begin
      conv_cyc_r <= conv_cyc_nxt;
    end
  end

  sequence conv_begin_s;
    state_r == ST_ACTIVE ##0 fall_evt;
  endsequence

  chk_busy_on_start: assert property ( // [RL3]
    @(posedge clk) disable iff (!resetn) conv_begin_s |=> busy_r && hold_r)
    else $error("busy or hold missing after start edge");

  chk_conv_length: assert property ( // [RL15]
    @(posedge clk) disable iff (!resetn)
    $fell(state_r == ST_CONVERT) |-> conv_cyc_r == CYC_W'(CONV_LEN) && !busy_r)
    else $error("conversion time wrong");

  chk_busy_ends: assert property ( // [RL4]
    @(posedge clk) disable iff (!resetn)
    $fell(state_r == ST_CONVERT) |-> !busy_r && oe_r)
    else $error("busy still high after conversion");

  chk_sleep_entry: assert property ( // [RL5]
    @(posedge clk) disable iff (!resetn)
    state_r == ST_CONVERT && timer_r == '0 && !cs_lvl |=> powered_down)
    else $error("no power-down with start held low");

  chk_wake_rise: assert property ( // [RL6]
    @(posedge clk) disable iff (!resetn)
    powered_down && rise_evt |=> state_r == ST_WAKE)
    else $error("rising edge did not wake");

  chk_track_after: assert property ( // [RL7]
    @(posedge clk) disable iff (!resetn) $fell(busy_r) |-> !hold_r)
    else $error("still in hold after conversion");

  chk_wake_hold: assert property ( // [RL17]
    @(posedge clk) disable iff (!resetn)
    $rose(state_r == ST_WAKE) |-> !hold_r ##[1:WAKE_CHK] state_r != ST_WAKE)
    else $error("wake interval too long");

  chk_wake_start: assert property ( // [RL17]
    @(posedge clk) disable iff (!resetn)
    state_r == ST_WAKE && timer_r == '0 && (fall_seen_r || fall_evt)
      |=> hold_r && busy_r && state_r == ST_CONVERT)
    else $error("hold not taken at end of wake");

  chk_release: assert property ( // [RL12]
    @(posedge clk) disable iff (!resetn) done_evt |=> !oe_r)
    else $error("data line not released after frame");

  chk_frame_zeros: assert property ( // [RL11]
    @(negedge sclk) disable iff (!lrst_n_r)
    cnt_r < CNT_W'(LEAD_ZEROS) |-> !serial_data_out)
    else $error("leading bit not zero");

  chk_msb_first: assert property ( // [RL18]
    @(negedge sclk) disable iff (!lrst_n_r)
    cnt_r == CNT_W'(LEAD_ZEROS) |-> serial_data_out == result_r[DW-1])
    else $error("first data bit not the msb");

  chk_last_hold: assert property ( // [RL12]
    @(negedge sclk) disable iff (!lrst_n_r)
    cnt_r == CNT_W'(FRAME_BITS - 1) |=> data_r == $past(data_r) && cnt_r == '0)
    else $error("last bit not held at frame end");

endmodule : adc_convert_ctrl

// >>> adc_ctrl_pkg.sv
// Purpose: shared constants and types for the sampling converter control and readout
// Assumes: core clock of 125 MHz; times are given in ns and turned into cycle counts here
// Notes:   cycle counts of least times round up to whole cycles
package adc_ctrl_pkg;

  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 8;
  localparam int CONV_TIME_NS   = 8000;  // conversion, timed from hold
  localparam int WAKE_TIME_NS   = 6000;  // rising edge to hold after power-down
  localparam int CONV_CYC       = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYC       = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------------------
  localparam int DATA_W         = 12;
  localparam int LEAD_ZEROS     = 4;
  localparam int FRAME_BITS     = 16;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic CONV_N_RST   = 1'h1;  // convert start idles high
  localparam logic TGL_RST      = 1'h0;

  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_CONVERT,
    ST_SLEEP,
    ST_WAKE
  } ctrl_state_t;

endpackage : adc_ctrl_pkg

// >>> sync_filter.sv
// Purpose: bring one asynchronous level into the clk domain
// Assumes: the level is slow against clk; pulses shorter than two cycles may be missed
// Notes:   the output follows once the second and third stages agree
`timescale 1ns/10ps
module sync_filter #(
  parameter logic RST_VAL = 1'h0
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic d_in,
  output logic      level_r
);

  logic [2:0] stage_r;
  logic [2:0] stage_nxt;
  logic       level_nxt;

  always_comb begin
    stage_nxt = {stage_r[1:0], d_in};
    level_nxt = level_r;
    // first stage is only ever read by the second
    if (stage_r[1] == stage_r[2]) begin
      level_nxt = stage_r[2];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage_r <= {3{RST_VAL}};
      level_r <= RST_VAL;
    end else begin
      stage_r <= stage_nxt;
      level_r <= level_nxt;
    end
  end

endmodule : sync_filter

// >>> host_model.sv
// Purpose: host side of the converter link: convert start pulses and sixteen-edge reads
// Assumes: sclk period 30 ns, standing low outside frames
// Notes:   a released data line reads back as the inverse of the driven value
`timescale 1ns/10ps
module host_model (
  input  wire logic clk,
  input  wire logic serial_data_out,
  input  wire logic serial_data_oe,
  output logic      convert_start_n,
  output logic      sclk
);
  // ---------------------------------------------------------------------------
  // line and timing
  // ---------------------------------------------------------------------------
  localparam int ACQ_CYC = 188;  // 1.5 us of acquisition at 8 ns
  logic line;
  // no stale value once the device lets go of the line
  assign line = serial_data_oe ? serial_data_out : ~serial_data_out;
  initial begin
    convert_start_n = 1'h1;
    sclk            = 1'h0;
  end
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic reset_clocks(input int n);
    repeat (n) begin
      #15;
      sclk = 1'h1;
      #15;
      sclk = 1'h0;
    end
  endtask : reset_clocks
  task automatic set_start(input logic lvl);
    @(posedge clk);
    convert_start_n <= lvl;
  endtask : set_start
  // reads only after busy falls; the long gap keeps reads clear of the next start
  task automatic acq_wait();
    repeat (ACQ_CYC) @(posedge clk);
  endtask : acq_wait
  task automatic read_frame(output logic [15:0] word, output logic oe_ok);
    oe_ok = 1'h1;
    #3;
    for (int k = 15; k >= 0; k--) begin
      #15;
      sclk = 1'h1;
      #7;
      word[k] = line;
      oe_ok   = oe_ok & serial_data_oe;
      #8;
      sclk = 1'h0;
    end
    // the last bit must still stand just after the sixteenth falling edge
    #5;
    oe_ok = oe_ok & serial_data_oe & (line === word[0]);
    // clock left low after the sixteenth edge
  endtask : read_frame
endmodule : host_model

// >>> tb_adc_convert_ctrl.sv
// Purpose: self-checking bench of convert start, busy, power-down and serial readout
// Assumes: shortened conversion and wake counts through parameters
// Notes:   conversion data drawn from an xorshift stream seeded with 57391
`timescale 1ns/10ps
module tb_adc_convert_ctrl;
  import adc_ctrl_pkg::*;
  localparam int CONV_T = 20;
  localparam int WAKE_T = 15;
  logic              clk;
  logic              resetn;
  logic              busy;
  logic              track_hold;
  logic              powered_down;
  logic              convert_start_n;
  logic              sclk;
  logic              serial_data_out;
  logic              serial_data_oe;
  logic [DATA_W-1:0] conv_data;
  logic [31:0]       seed;
  int                err_count;
  int                samples_checked;
  int                hi_cnt;
  int                th_cnt;
  int                cyc;
  // ---------------------------------------------------------------------------
  // instances and clock
  // ---------------------------------------------------------------------------
  adc_convert_ctrl #(.CONV_LEN(CONV_T), .WAKE_LEN(WAKE_T)) u_adc_convert_ctrl (
    .clk             (clk),
    .resetn          (resetn),
    .convert_start_n (convert_start_n),
    .conv_data       (conv_data),
    .busy            (busy),
    .track_hold      (track_hold),
    .powered_down    (powered_down),
    .sclk            (sclk),
    .serial_data_out (serial_data_out),
    .serial_data_oe  (serial_data_oe)
  );
  host_model u_host_model (
    .clk             (clk),
    .serial_data_out (serial_data_out),
    .serial_data_oe  (serial_data_oe),
    .convert_start_n (convert_start_n),
    .sclk            (sclk)
  );
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc    <= cyc + 1;
    hi_cnt <= (busy === 1'h1) ? hi_cnt + 1 : hi_cnt;
    th_cnt <= (track_hold === 1'h1) ? th_cnt + 1 : th_cnt;
  end
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  function automatic logic [15:0] frame_of(input logic [DATA_W-1:0] d);
    return {4'h0, d};
  endfunction : frame_of
  function automatic logic pick(input int sel);
    case (sel)
      0:       return busy;
      1:       return powered_down;
      2:       return serial_data_oe;
      default: return track_hold;
    endcase
  endfunction : pick
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'h1) begin
      err_count++;
      $display("BAD t=%0t %s", $time, msg);
    end
  endtask : check
  // bounded wait, sampled 1 ns after the edge so design updates have landed
  task automatic wait_for(input int sel, input logic lvl, output int n);
    n = 0;
    #1;
    while (pick(sel) !== lvl) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 2000) begin
        check(1'h0, "wait timed out");
        end_sim();
      end
    end
  endtask : wait_for
  task automatic read_check();
    logic [15:0] word;
    logic        oe_ok;
    int          n;
    u_host_model.read_frame(word, oe_ok);
    check(oe_ok && word === frame_of(conv_data), "frame content");
    wait_for(2, 1'h0, n);
    check(n <= 10 && serial_data_out === 1'h0, "line not released");
  endtask : read_check
  // ---------------------------------------------------------------------------
  // one conversion, high sampling or with power-down and wake
  // ---------------------------------------------------------------------------
  task automatic run(input logic [DATA_W-1:0] d, input logic sleep, input logic retrig);
    int n;
    int b0;
    int t0;
    @(posedge clk);
    conv_data <= d;
    b0 = hi_cnt;
    u_host_model.set_start(1'h0);
    if (!sleep) begin
      repeat (5) @(posedge clk);
      u_host_model.set_start(1'h1);
    end
    wait_for(0, 1'h1, n);
    check(n <= 10, "busy late");
    check(track_hold === 1'h1, "no hold");
    if (retrig && !sleep) begin
      u_host_model.set_start(1'h0);
      repeat (5) @(posedge clk);
      u_host_model.set_start(1'h1);
    end
    wait_for(0, 1'h0, n);
    check(hi_cnt - b0 == CONV_T, "busy length");
    check(track_hold === 1'h0 && serial_data_oe === 1'h1, "not tracking");
    check(powered_down === sleep, "power-down state");
    read_check();
    if (sleep) begin
      u_host_model.acq_wait();
      seed = xorshift(seed);
      conv_data <= seed[DATA_W-1:0];
      u_host_model.set_start(1'h1);
      wait_for(1, 1'h0, n);
      check(n <= 10, "no wake");
      t0 = cyc;
      repeat (3) @(posedge clk);
      u_host_model.set_start(1'h0);
      wait_for(3, 1'h1, n);
      check(cyc - t0 >= WAKE_T - 2 && cyc - t0 <= WAKE_T + 2, "hold delay");
      check(busy === 1'h1, "busy in wake");
      b0 = th_cnt;
      u_host_model.set_start(1'h1);
      wait_for(3, 1'h0, n);
      check(th_cnt - b0 == CONV_T && busy === 1'h0, "wake conversion");
      read_check();
    end
    u_host_model.acq_wait();
  endtask : run
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    resetn          = 1'h0;
    conv_data       = 12'h000;
    seed            = 32'h0000E02F;
    err_count       = 0;
    samples_checked = 0;
    hi_cnt          = 0;
    th_cnt          = 0;
    cyc             = 0;
    fork
      u_host_model.reset_clocks(4);
    join_none
    repeat (16) @(posedge clk);
    resetn <= 1'h1;
    repeat (4) @(posedge clk);
    // two more falling edges carry the released reset through the serial side's two flops
    u_host_model.reset_clocks(2);
    @(posedge clk);
    #1;
    check(busy === 1'h0 && track_hold === 1'h0 && powered_down === 1'h0, "reset outputs");
    check(serial_data_oe === 1'h0, "reset enable");
    run(12'h000, 1'h0, 1'h0);
    run(12'hFFF, 1'h0, 1'h1);
    run(12'h801, 1'h1, 1'h0);
    for (int i = 0; i < 8; i++) begin
      seed = xorshift(seed);
      run(seed[DATA_W-1:0], seed[20], seed[25]);
    end
    end_sim();
  end
endmodule : tb_adc_convert_ctrl
